// ===== src/fault_classify.sv
// Classifier: decides how a single access is answered.
// Assumes all inputs are stable while req is high.
`timescale 1ns/10ps
`default_nettype none
module fault_classify
	import fault_resp_pkg::*;
(
	// Access attributes
	input  wire logic is_write,
	input  wire logic std_raz,
	input  wire logic std_rao,
	input  wire logic std_err,
	input  wire logic unalloc,
	input  wire logic read_only,
	input  wire logic page_absent,
	input  wire logic secure_reg,
	input  wire logic nonsecure,
	input  wire logic dev_off,
	input  wire logic bad_value,
	// Node controls
	input  wire logic node_present,
	input  wire logic err_en,
	// Result
	output logic      fault,
	output var class_t cls,
	output logic [7:0] code
);
	logic reserved;
	logic illegal_acc;
	logic err_ok;
	assign reserved    = unalloc | (is_write & read_only);
	assign illegal_acc = (secure_reg & nonsecure) | (is_write & bad_value);
	assign err_ok      = node_present & err_en;
	always_comb begin
		fault = 1'b1;
		cls   = CL_RAZ;
		code  = ESC_NONE;
		if (std_err) begin
			cls  = err_ok ? CL_ERR : CL_RAZ;
			code = ESC_ILLEGAL_ACC;
		end else if (std_rao) begin
			cls  = CL_RAO;
			code = ESC_ILLEGAL_ACC;
		end else if (std_raz | reserved) begin
			cls  = CL_RAZ;
			code = ESC_ILLEGAL_ACC;
		end else if (page_absent) begin
			cls  = err_ok ? CL_ERR : CL_RAZ;
			code = ESC_ILLEGAL_ADR;
		end else if (dev_off) begin
			cls  = CL_RAZ;
			code = ESC_ILLEGAL_STA;
		end else if (illegal_acc) begin
			cls  = CL_RAZ;
			code = ESC_ILLEGAL_ACC;
		end else begin
			fault = 1'b0;
			cls   = CL_OK;
		end
	end
endmodule
`default_nettype wire

// ===== src/fault_resp_pkg.sv
// Constants for the software-fault access responder.
// Assumes a simple one-cycle request/answer bus facing the requester.
package fault_resp_pkg;
	// ********************************
	// Error status codes
	// ********************************
	localparam logic [7:0] ESC_NONE        = 8'h00;
	localparam logic [7:0] ESC_ILLEGAL_ADR = 8'h0D;
	localparam logic [7:0] ESC_ILLEGAL_ACC = 8'h0E;
	localparam logic [7:0] ESC_ILLEGAL_STA = 8'h0F;
	// ********************************
	// Reset values, read values and page offset width
	// ********************************
	localparam logic       ERR_EN_RESET  = 1'b0;
	localparam logic       IRQ_EN_RESET  = 1'b0;
	localparam logic [31:0] RAZ_VALUE    = 32'h0000_0000;
	localparam logic [31:0] RAO_VALUE    = 32'hFFFF_FFFF;
	localparam int          PAGE_BITS    = 16;
	// Answer class
	typedef enum logic [3:0] {
		CL_OK   = 4'b0001,
		CL_RAZ  = 4'b0010,
		CL_RAO  = 4'b0100,
		CL_ERR  = 4'b1000
	} class_t;
endpackage

// ===== src/fault_responder.sv
// Top of the software-fault access responder.
// Assumes the requester holds a request for one cycle and the target supplies read data combinationally.
`timescale 1ns/10ps
`default_nettype none
module fault_responder
	import fault_resp_pkg::*;
#(
	parameter int ADDR_W    = 32,
	parameter int PBITS     = PAGE_BITS,
	parameter bit HAS_NODE  = 1'b1
)(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// Trusted configuration
	input  wire logic              cfg_we,
	input  wire logic [ADDR_W-1:0] cfg_page,
	input  wire logic              cfg_absent,
	input  wire logic              cfg_err_en,
	input  wire logic              cfg_irq_en,
	input  wire logic              cfg_trusted,
	input  wire logic              rec_clear,
	// Request from requester
	input  wire logic              req,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [31:0]       req_wdata,
	input  wire logic              req_nonsecure,
	// Target attributes
	input  wire logic              std_raz,
	input  wire logic              std_rao,
	input  wire logic              std_err,
	input  wire logic              unalloc,
	input  wire logic              read_only,
	input  wire logic              secure_reg,
	input  wire logic              dev_off,
	input  wire logic              bad_value,
	input  wire logic [31:0]       tgt_rdata,
	// Target write
	output logic                   tgt_we,
	output logic [31:0]            tgt_wdata,
	// Answer to requester
	output logic                   rsp_valid,
	output logic [31:0]            rsp_rdata,
	output logic                   rsp_err,
	// Error record
	output logic                   rec_valid,
	output logic [7:0]             error_status_code,
	output logic                   fault_irq
);
	// ********************************
	// Reset synchroniser
	// ********************************
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ********************************
	// Trusted configuration
	// ********************************
	logic              err_en_q;
	logic              irq_en_q;
	logic              absent_q;
	logic [ADDR_W-1:0] page_q;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			err_en_q <= ERR_EN_RESET;
			irq_en_q <= IRQ_EN_RESET;
			absent_q <= 1'b0;
			page_q   <= '0;
		end else if (cfg_we && cfg_trusted) begin
			err_en_q <= cfg_err_en & HAS_NODE;
			irq_en_q <= cfg_irq_en & HAS_NODE;
			absent_q <= cfg_absent;
			page_q   <= cfg_page;
		end
	end

	// ********************************
	// Classification
	// ********************************
	logic              page_absent;
	logic              fault;
	class_t            cls;
	logic [7:0]        code;
	logic [ADDR_W-1:0] page_mask;
	assign page_mask   = {ADDR_W{1'b1}} << PBITS;
	assign page_absent = absent_q && ((req_addr & page_mask) == (page_q & page_mask));

	fault_classify u_cls (
		.is_write     (req_write),
		.std_raz      (std_raz),
		.std_rao      (std_rao),
		.std_err      (std_err),
		.unalloc      (unalloc),
		.read_only    (read_only),
		.page_absent  (page_absent),
		.secure_reg   (secure_reg),
		.nonsecure    (req_nonsecure),
		.dev_off      (dev_off),
		.bad_value    (bad_value),
		.node_present (HAS_NODE),
		.err_en       (err_en_q),
		.fault        (fault),
		.cls          (cls),
		.code         (code)
	);

	// ********************************
	// Target write path
	// ********************************
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tgt_we    <= 1'b0;
			tgt_wdata <= RAZ_VALUE;
		end else begin
			tgt_we    <= req && req_write && !fault;
			tgt_wdata <= req_wdata;
		end
	end

	// ********************************
	// Answer
	// ********************************
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= RAZ_VALUE;
			rsp_err   <= 1'b0;
		end else begin
			rsp_valid <= req;
			rsp_err   <= req && (cls == CL_ERR);
			if (!req || req_write) begin
				rsp_rdata <= RAZ_VALUE;
			end else begin
				case (cls)
					CL_OK:   rsp_rdata <= tgt_rdata;
					CL_RAO:  rsp_rdata <= RAO_VALUE;
					CL_RAZ:  rsp_rdata <= RAZ_VALUE;
					CL_ERR:  rsp_rdata <= RAZ_VALUE;
					default: rsp_rdata <= RAZ_VALUE;
				endcase
			end
		end
	end

	// ********************************
	// Error record and interrupt
	// ********************************
	logic rec_set;
	assign rec_set = HAS_NODE && req && fault;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rec_valid         <= 1'b0;
			error_status_code <= ESC_NONE;
		end else if (rec_set) begin
			rec_valid         <= 1'b1;                                // set wins over clear
			error_status_code <= code;
		end else if (rec_clear) begin
			rec_valid         <= 1'b0;
			error_status_code <= ESC_NONE;
		end
	end
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fault_irq <= 1'b0;
		end else begin
			fault_irq <= (rec_set | (rec_valid & ~rec_clear)) & irq_en_q;
		end
	end

	// ********************************
	// Checks
	// ********************************
	sequence s_err_en_off;
		req && !err_en_q;
	endsequence
	AST_ERR_RESET_OFF: assert property (@(posedge mclk) $rose(rst_n_q) |-> !err_en_q && !irq_en_q)
		else $error("enables not disabled after reset");
	AST_NO_ERR_WHEN_OFF: assert property (@(posedge mclk) disable iff (!rst_n_q)
		s_err_en_off |=> !rsp_err)
		else $error("error response with enable clear");
	AST_NO_NODE_NO_ERR: assert property (@(posedge mclk) disable iff (!rst_n_q) rsp_err |-> HAS_NODE && $past(err_en_q))
		else $error("error response without node");
	AST_RAO_READ: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(req && !req_write && std_rao && !std_err) |=> rsp_rdata == RAO_VALUE)
		else $error("rao read not all ones");
	AST_RESERVED_RAZ: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(req && !req_write && unalloc && !std_err && !std_rao) |=> rsp_rdata == RAZ_VALUE)
		else $error("reserved read not zero");
	AST_FAULT_WI: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(req && req_write && (read_only || dev_off || bad_value)) |=> !tgt_we)
		else $error("faulting write reached target");
	AST_ADDR_CODE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(HAS_NODE && req && page_absent && !std_err && !std_rao && !std_raz && !unalloc
		 && !(req_write && read_only)) |=> error_status_code == ESC_ILLEGAL_ADR)
		else $error("wrong code for illegal address");
	AST_STATE_CODE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(HAS_NODE && req && fault && cls == CL_RAZ && dev_off && !page_absent && !std_err && !std_rao
		 && !std_raz && !unalloc && !(req_write && read_only)) |=> error_status_code == ESC_ILLEGAL_STA)
		else $error("wrong code for illegal state");
	AST_ABSENT_ERR: assert property (@(posedge mclk) disable iff (!rst_n_q)
		(HAS_NODE && err_en_q && req && page_absent && !std_rao && !std_raz && !unalloc
		 && !(req_write && read_only)) |=> rsp_err && rsp_valid)
		else $error("no error for not-present page");
endmodule
`default_nettype wire

// ===== tb/bus_requester.sv
// Requester model: issues one-cycle accesses and collects the answer.
// Assumes the responder answers one cycle after the request edge.
`timescale 1ns/10ps
`default_nettype none
module bus_requester (
	// Clock
	input  wire logic        mclk,
	// Request
	output var logic         req,
	output var logic         req_write,
	output var logic [31:0]  req_addr,
	output var logic [31:0]  req_wdata,
	output var logic         req_nonsecure,
	// Answer
	input  wire logic        rsp_valid,
	input  wire logic [31:0] rsp_rdata,
	input  wire logic        rsp_err
);
	initial begin
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 32'h0;
		req_wdata = 32'h0;
		req_nonsecure = 1'b0;
	end
	// Released address and write data lines show the inverse so stale values are never trusted
	task automatic do_access(input logic w, input logic [31:0] a, d, input logic ns,
		output logic [31:0] rd, output logic er, output logic v);
		@(negedge mclk);
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_nonsecure = ns;
		@(negedge mclk);
		rd = rsp_rdata;
		er = rsp_err;
		v = rsp_valid;
		req = 1'b0;
		req_addr = ~a;
		req_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// ===== tb/software_fault_access_responder_test.sv
// Testbench for the software-fault access responder.
// Assumes the responder package and the requester model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module software_fault_access_responder_test;
	import fault_resp_pkg::*;
	logic mclk = 1'b0, resetn = 1'b0, cfg_we = 1'b0, cfg_absent, cfg_err_en, cfg_irq_en, cfg_trusted, rec_clear = 1'b0;
	logic std_raz, std_rao, std_err, unalloc, read_only, secure_reg, dev_off, bad_value;
	logic [31:0] cfg_page = 32'h0004_0000, tgt_rdata = 32'h5A5A_1234;
	wire logic req, req_write, req_nonsecure, tgt_we, rsp_valid, rsp_err, rec_valid, fault_irq;
	wire logic [31:0] req_addr, req_wdata, tgt_wdata, rsp_rdata;
	wire logic [7:0] error_status_code;
	int n_mismatch = 0, compares = 0, cyc = 0;
	always #20 mclk = ~mclk;
	logic [7:0] at = 8'h00;
	assign {std_raz, std_rao, std_err, unalloc, read_only, secure_reg, dev_off, bad_value} = at;
	fault_responder u_fault_responder (.mclk(mclk), .resetn(resetn), .cfg_we(cfg_we), .cfg_page(cfg_page),
		.cfg_absent(cfg_absent), .cfg_err_en(cfg_err_en), .cfg_irq_en(cfg_irq_en), .cfg_trusted(cfg_trusted),
		.rec_clear(rec_clear), .req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_nonsecure(req_nonsecure), .std_raz(std_raz), .std_rao(std_rao), .std_err(std_err),
		.unalloc(unalloc), .read_only(read_only), .secure_reg(secure_reg), .dev_off(dev_off),
		.bad_value(bad_value), .tgt_rdata(tgt_rdata), .tgt_we(tgt_we), .tgt_wdata(tgt_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .rec_valid(rec_valid),
		.error_status_code(error_status_code), .fault_irq(fault_irq));
	bus_requester u_bus_requester (.mclk(mclk), .req(req), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_nonsecure(req_nonsecure), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
	// ****************************
	// Shared tasks
	// ****************************
	task automatic finish_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cfg(input logic tr, ab, ee, ie);
		@(negedge mclk);
		{cfg_we, cfg_trusted, cfg_absent, cfg_err_en, cfg_irq_en} = {1'b1, tr, ab, ee, ie};
		@(negedge mclk);
		cfg_we = 1'b0;
	endtask
	// One access: attributes, then answer, error flag and target write
	task automatic acc(input logic [7:0] a8, input logic w, input logic [31:0] a, input logic ns,
		input logic [31:0] xd, input logic xe, xw);
		logic [31:0] rd;
		logic er, v;
		at = a8;
		u_bus_requester.do_access(w, a, 32'hC0DE_0001, ns, rd, er, v);
		check("rsp_valid", {31'h0, v}, 32'h1);
		check("rsp_rdata", rd, xd);
		check("rsp_err", {31'h0, er}, {31'h0, xe});
		check("tgt_we", {31'h0, tgt_we}, {31'h0, xw});
		if (xw)
			check("tgt_wdata", tgt_wdata, 32'hC0DE_0001);
		at = 8'h00;
	endtask
	task automatic code(input logic [7:0] x);
		check("code", {24'h0, error_status_code}, {24'h0, x});
	endtask
	// ****************************
	// Scenarios
	// ****************************
	task automatic t_reset();
		check("irq", {31'h0, fault_irq}, 32'h0);
		acc(8'h20, 1'b0, 32'h100, 1'b0, RAZ_VALUE, 1'b0, 1'b0);
		check("irq", {31'h0, fault_irq}, 32'h0);
	endtask
	task automatic t_plain();
		acc(8'h00, 1'b0, 32'h104, 1'b0, 32'h5A5A_1234, 1'b0, 1'b0);
		acc(8'h00, 1'b1, 32'h104, 1'b0, 32'h0, 1'b0, 1'b1);
		acc(8'h10, 1'b0, 32'h108, 1'b0, RAZ_VALUE, 1'b0, 1'b0);
		acc(8'h10, 1'b1, 32'h108, 1'b0, 32'h0, 1'b0, 1'b0);
		acc(8'h08, 1'b1, 32'h10C, 1'b0, 32'h0, 1'b0, 1'b0);
		code(ESC_ILLEGAL_ACC);
	endtask
	task automatic t_std();
		acc(8'h40, 1'b0, 32'h110, 1'b0, RAO_VALUE, 1'b0, 1'b0);
		acc(8'h40, 1'b1, 32'h110, 1'b0, 32'h0, 1'b0, 1'b0);
		acc(8'hD0, 1'b0, 32'h114, 1'b0, RAO_VALUE, 1'b0, 1'b0);
		cfg(1'b1, 1'b0, 1'b1, 1'b0);
		acc(8'h70, 1'b0, 32'h118, 1'b0, 32'h0, 1'b1, 1'b0);
	endtask
	task automatic t_absent();
		cfg(1'b0, 1'b1, 1'b1, 1'b0);
		acc(8'h00, 1'b0, 32'h0004_0010, 1'b0, 32'h5A5A_1234, 1'b0, 1'b0);
		cfg(1'b1, 1'b1, 1'b0, 1'b0);
		acc(8'h00, 1'b0, 32'h0004_0010, 1'b0, RAZ_VALUE, 1'b0, 1'b0);
		acc(8'h00, 1'b1, 32'h0004_0010, 1'b0, 32'h0, 1'b0, 1'b0);
		cfg(1'b1, 1'b1, 1'b1, 1'b0);
		acc(8'h00, 1'b0, 32'h0004_FFFC, 1'b0, 32'h0, 1'b1, 1'b0);
		code(ESC_ILLEGAL_ADR);
		acc(8'h00, 1'b0, 32'h0005_0000, 1'b0, 32'h5A5A_1234, 1'b0, 1'b0);
	endtask
	task automatic t_faults();
		cfg(1'b1, 1'b0, 1'b0, 1'b1);
		acc(8'h02, 1'b0, 32'h120, 1'b0, RAZ_VALUE, 1'b0, 1'b0);
		code(ESC_ILLEGAL_STA);
		check("irq", {31'h0, fault_irq}, 32'h1);
		@(negedge mclk);
		rec_clear = 1'b1;
		@(negedge mclk);
		rec_clear = 1'b0;
		check("rec_valid", {31'h0, rec_valid}, 32'h0);
		check("irq", {31'h0, fault_irq}, 32'h0);
		acc(8'h04, 1'b0, 32'h124, 1'b1, RAZ_VALUE, 1'b0, 1'b0);
		code(ESC_ILLEGAL_ACC);
		acc(8'h04, 1'b0, 32'h124, 1'b0, 32'h5A5A_1234, 1'b0, 1'b0);
		acc(8'h01, 1'b1, 32'h128, 1'b0, 32'h0, 1'b0, 1'b0);
	endtask
	// Reset in mid-run with every enable and the absent page set
	task automatic t_rereset();
		cfg(1'b1, 1'b1, 1'b1, 1'b1);
		@(negedge mclk);
		resetn = 1'b0;
		repeat (2) @(negedge mclk);
		check("rec_valid", {31'h0, rec_valid}, 32'h0);
		resetn = 1'b1;
		repeat (3) @(negedge mclk);
		acc(8'h00, 1'b0, 32'h0004_0010, 1'b0, 32'h5A5A_1234, 1'b0, 1'b0);
		acc(8'h20, 1'b0, 32'h100, 1'b0, RAZ_VALUE, 1'b0, 1'b0);
		check("irq", {31'h0, fault_irq}, 32'h0);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		{cfg_absent, cfg_err_en, cfg_irq_en, cfg_trusted} = 4'h0;
		repeat (12) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		t_reset();
		t_plain();
		t_std();
		t_absent();
		t_faults();
		t_rereset();
		finish_test();
	end
endmodule
`default_nettype wire
